// ===== common/spcf_pkg.sv
package spcf_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL1  = 8'h04;
	localparam logic [7:0] OFS_CTRL2  = 8'h08;
	localparam logic [7:0] OFS_BUF    = 8'h0c;
	// Primary control register fields
	localparam int B1_WORD   = 10;
	localparam int B1_SAMPLE = 9;
	localparam int B1_EDGE   = 8;
	localparam int B1_SSUSE  = 7;
	localparam int B1_CKP    = 6;
	localparam int B1_ROLE   = 5;
	localparam int B1_SEC_LO = 2;
	localparam int B1_PRI_LO = 0;
	localparam logic [15:0] CTRL1_MASK = 16'h07ff;
	// Framing control register fields
	localparam int B2_FRM   = 15;
	localparam int B2_FSD   = 14;
	localparam int B2_FPOL  = 13;
	localparam int B2_FEDGE = 1;
	localparam int B2_DEEP  = 0;
	localparam logic [15:0] CTRL2_MASK = 16'he003;
	// Status register fields
	localparam int BS_EN  = 15;
	localparam int BS_ROV = 6;
	localparam int BS_TBF = 1;
	localparam int BS_RBF = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// Receive store depth and word sizes
	localparam logic [2:0] RX_LIM_DEEP = 3'h4;
	localparam logic [2:0] RX_LIM_LEG  = 3'h1;
	localparam logic [4:0] BITS_WORD   = 5'h10;
	localparam logic [4:0] BITS_BYTE   = 5'h08;
	localparam logic [9:0] RATIO_MIN   = 10'h002;
	// Engine states
	typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_XFER, ST_DONE} spcf_state_t;
	// Primary divide ratio from its 2-bit code
	function automatic logic [9:0] pri_ratio(input logic [1:0] c);
		unique case (c)
			2'h3: pri_ratio = 10'h001;
			2'h2: pri_ratio = 10'h004;
			2'h1: pri_ratio = 10'h010;
			default: pri_ratio = 10'h040;
		endcase
	endfunction
	// Secondary divide ratio is eight minus the code
	function automatic logic [9:0] sec_ratio(input logic [2:0] c);
		sec_ratio = 10'h008 - {7'h00, c};
	endfunction
endpackage

// ===== rtl/spcf_baud.sv
`timescale 1ns/100ps
`default_nettype none
// Bit-window timer for master role
module spcf_baud (
	input  wire logic       core_clk,   // Instruction clock
	input  wire logic       rst,        // Sync reset, high
	input  wire logic       run,        // Window timer running
	input  wire logic [1:0] pri,        // Primary divider code
	input  wire logic [2:0] sec,        // Secondary divider code
	output logic            first_half, // Window in first half
	output logic            bit_mid,    // Middle of bit window
	output logic            bit_end     // Last cycle of window
);
	logic [9:0] ratio;   // Cycles per bit window
	logic [9:0] prod;    // Raw divider product
	logic [9:0] half;    // Middle point
	logic [9:0] cnt_r;   // Window position
	logic [9:0] cnt_nxt; // Next position

	// Ratio 1:1 cannot toggle a registered pin, so floor at two
	always_comb begin
		prod = 10'(spcf_pkg::pri_ratio(pri) * spcf_pkg::sec_ratio(sec)); // [R8] [R9] [R10] [R11]
		ratio = (prod < spcf_pkg::RATIO_MIN) ? spcf_pkg::RATIO_MIN : prod;
		half = ratio >> 1;
		first_half = cnt_r < half;
		bit_mid = run && (cnt_r == half);
		bit_end = run && (cnt_r == ratio - 10'h001);
	end

	// Counter wraps every ratio cycles while running
	always_comb begin
		if (!run || bit_end) begin
			cnt_nxt = 10'h000;
		end else begin
			cnt_nxt = cnt_r + 10'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_r <= 10'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	a_window_wrap: assert property (@(posedge core_clk) disable iff (rst) // [R11]
		run && bit_end |=> cnt_r == 10'h000) else $error("window did not wrap");
	a_div_codes: assert property (@(posedge core_clk) disable iff (rst) // [R9]
		(pri == 2'h2 && sec == 3'h2) |-> ratio == 10'h018) else $error("ratio wrong");
endmodule // spcf_baud
`default_nettype wire

// ===== rtl/spcf_top.sv
// Behaviour
// [R1] Master samples at bit end or middle
// [R2] Software keeps sample phase clear in slave
// [R3] Edge bit picks which clock transition shifts
// [R4] Edge bit ignored while framed
// [R5] Slave select pin used only when enabled
// [R6] Polarity bit sets clock idle level
// [R7] Role bit picks master or slave
// [R8] Secondary divider codes 7, 6, 0
// [R9] Secondary ratio is eight minus code
// [R10] Primary divider 1, 4, 16, 64
// [R11] Clock rate is core over product; a product of one runs at core over two
// [R12] Framing bit enables frame sync pulse
// [R13] Sync direction bit: input or output
// [R14] Sync polarity bit high or low active
// [R15] Sync coincides with or precedes first bit
// [R16] Buffer bit selects deep receive store
// [R17] Unused bits read zero, reset zero
// [R18] Word size bit: 16 or 8 bits
// [R19] Master starts when buffer written
// [R20] Full receive store drops data, flags overflow
// [R21] Enable bit hands pins to port
`timescale 1ns/100ps
`default_nettype none
module spcf_top (
	input  wire logic        core_clk,            // Instruction clock
	input  wire logic        rst,                 // Sync reset, high
	input  wire logic        psel,                // APB select
	input  wire logic        penable,             // APB enable
	input  wire logic        pwrite,              // APB direction
	input  wire logic [7:0]  paddr,               // APB byte address
	input  wire logic [31:0] pwdata,              // APB write data
	output logic      [31:0] prdata,              // APB read data
	output logic             pready,              // APB ready
	output logic             pslverr,             // APB error
	input  wire logic        serial_clock_pin_i,  // Clock pin level
	output logic             serial_clock_pin_o,  // Clock pin drive
	output logic             serial_clock_pin_oe, // Clock pin enable
	output logic             serial_out_pin_o,    // Data out level
	output logic             serial_out_pin_oe,   // Data out enable
	input  wire logic        serial_in_pin_i,     // Data in level
	input  wire logic        slave_select_pin_n_i,  // Select or sync in
	output logic             slave_select_pin_n_o,  // Sync pulse drive
	output logic             slave_select_pin_n_oe  // Sync pulse enable
);
	// Register file
	logic [15:0] ctrl1_r, ctrl1_nxt; // Primary control
	logic [15:0] ctrl2_r, ctrl2_nxt; // Framing control
	logic        en_r, en_nxt;       // Port enable
	logic        rov_r, rov_nxt;     // Receive overflow
	logic        tbf_r, tbf_nxt;     // Transmit holding full
	logic [15:0] tx_r, tx_nxt;       // Transmit holding word
	// APB answer
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	// Serial engine
	spcf_pkg::spcf_state_t state_r, state_nxt;
	logic [15:0] sr_r, sr_nxt;       // Transmit shifter
	logic [15:0] rsr_r, rsr_nxt;     // Receive shifter
	logic [4:0]  bitcnt_r, bitcnt_nxt; // Bits done
	logic        sck_q_r;            // Previous clock pin level
	logic        frame_on_r, frame_on_nxt; // Slave frame in progress
	// Receive store
	logic [15:0] rx_mem [4];         // Receive words
	logic [1:0]  rx_rd_r, rx_rd_nxt; // Oldest entry
	logic [2:0]  rx_cnt_r, rx_cnt_nxt; // Entries held
	// Pin registers
	logic sck_o_r, sck_o_nxt, sck_oe_r, sck_oe_nxt;
	logic sdo_o_r, sdo_o_nxt, sdo_oe_r, sdo_oe_nxt;
	logic ss_o_r, ss_o_nxt, ss_oe_r, ss_oe_nxt;
	// Decoded controls
	logic       master, framed, fsd, fpol, fedge, deep, cke_eff, sample_phase_sel, clock_idle_level;
	logic [4:0] nbits;
	logic [2:0] rx_lim;
	logic       first_half, bit_mid, bit_end, run;
	logic       setup, wr_acc, rd_pop, push, sync_seen, sel;
	logic       lead, trail, sample, fs_pulse;
	logic [15:0] rx_word;
	logic [1:0]  rx_wr;

	// Only the four word offsets answer without error
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == spcf_pkg::OFS_STATUS) || (a == spcf_pkg::OFS_CTRL1) ||
			(a == spcf_pkg::OFS_CTRL2) || (a == spcf_pkg::OFS_BUF);
	endfunction

	// Field decode
	always_comb begin
		master  = ctrl1_r[spcf_pkg::B1_ROLE];                 // [R7]
		framed  = ctrl2_r[spcf_pkg::B2_FRM];                  // [R12]
		fsd     = ctrl2_r[spcf_pkg::B2_FSD];
		fpol    = ctrl2_r[spcf_pkg::B2_FPOL];
		fedge   = ctrl2_r[spcf_pkg::B2_FEDGE];
		deep    = ctrl2_r[spcf_pkg::B2_DEEP];
		cke_eff = ctrl1_r[spcf_pkg::B1_EDGE] && !framed;      // [R4]
		sample_phase_sel     = ctrl1_r[spcf_pkg::B1_SAMPLE];               // [R2]
		clock_idle_level     = ctrl1_r[spcf_pkg::B1_CKP];
		nbits   = ctrl1_r[spcf_pkg::B1_WORD] ? spcf_pkg::BITS_WORD : spcf_pkg::BITS_BYTE; // [R18]
		rx_lim  = deep ? spcf_pkg::RX_LIM_DEEP : spcf_pkg::RX_LIM_LEG; // [R16]
		run     = master && (state_r == spcf_pkg::ST_SYNC || state_r == spcf_pkg::ST_XFER);
	end

	spcf_baud u_baud (
		.core_clk   (core_clk),
		.rst        (rst),
		.run        (run),
		.pri        (ctrl1_r[spcf_pkg::B1_PRI_LO +: 2]),
		.sec        (ctrl1_r[spcf_pkg::B1_SEC_LO +: 3]),
		.first_half (first_half),
		.bit_mid    (bit_mid),
		.bit_end    (bit_end)
	);

	// Link events and selection
	always_comb begin
		lead  = (serial_clock_pin_i ^ clock_idle_level) && !(sck_q_r ^ clock_idle_level);
		trail = !(serial_clock_pin_i ^ clock_idle_level) && (sck_q_r ^ clock_idle_level);
		sync_seen = framed && fsd && (slave_select_pin_n_i == fpol); // [R13] [R14]
		if (framed) begin
			sel = fsd ? (frame_on_r || sync_seen) : 1'b1;
		end else begin
			sel = !ctrl1_r[spcf_pkg::B1_SSUSE] || !slave_select_pin_n_i; // [R5]
		end
		// Master: middle of window unless end phase chosen; slave: on a clock edge
		if (master) begin
			sample = sample_phase_sel ? bit_end : bit_mid; // [R1]
		end else begin
			sample = cke_eff ? lead : trail;  // [R3]
		end
	end

	// APB slave: answers in the cycle after setup, no waits
	always_comb begin
		setup  = psel && !penable;
		wr_acc = psel && penable && pready_r && pwrite;
		rd_pop = psel && penable && pready_r && !pwrite && (paddr == spcf_pkg::OFS_BUF) &&
			(rx_cnt_r != 3'h0);
		pready_nxt  = setup;
		pslverr_nxt = setup && !mapped(paddr);
		prdata_nxt  = prdata_r;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				spcf_pkg::OFS_STATUS: begin
					prdata_nxt[spcf_pkg::BS_EN]  = en_r;
					prdata_nxt[spcf_pkg::BS_ROV] = rov_r;
					prdata_nxt[spcf_pkg::BS_TBF] = tbf_r;
					prdata_nxt[spcf_pkg::BS_RBF] = rx_cnt_r >= rx_lim;
				end
				spcf_pkg::OFS_CTRL1: prdata_nxt[15:0] = ctrl1_r;
				spcf_pkg::OFS_CTRL2: prdata_nxt[15:0] = ctrl2_r; // [R17]
				spcf_pkg::OFS_BUF:   prdata_nxt[15:0] = rx_mem[rx_rd_r];
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Control registers; unimplemented bits never stored
	always_comb begin
		ctrl1_nxt = ctrl1_r;
		ctrl2_nxt = ctrl2_r;
		en_nxt    = en_r;
		if (wr_acc && paddr == spcf_pkg::OFS_CTRL1) begin
			ctrl1_nxt = pwdata[15:0] & spcf_pkg::CTRL1_MASK;
		end
		if (wr_acc && paddr == spcf_pkg::OFS_CTRL2) begin
			ctrl2_nxt = pwdata[15:0] & spcf_pkg::CTRL2_MASK; // [R17]
		end
		if (wr_acc && paddr == spcf_pkg::OFS_STATUS) begin
			en_nxt = pwdata[spcf_pkg::BS_EN]; // [R21]
		end
	end

	// Serial engine and its buffer flags
	always_comb begin
		state_nxt    = state_r;
		sr_nxt       = sr_r;
		rsr_nxt      = rsr_r;
		bitcnt_nxt   = bitcnt_r;
		frame_on_nxt = frame_on_r;
		tx_nxt       = tx_r;
		tbf_nxt      = tbf_r;
		push         = 1'b0;
		rx_word      = ctrl1_r[spcf_pkg::B1_WORD] ? rsr_r : {8'h00, rsr_r[7:0]};
		unique case (state_r)
			spcf_pkg::ST_IDLE: begin
				// Master waits for data, and for an incoming sync if it listens
				if (en_r && ((master && tbf_r && (!framed || !fsd || sync_seen)) ||
					(!master && sel))) begin // [R19]
					sr_nxt     = tx_r;
					tbf_nxt    = 1'b0;
					bitcnt_nxt = 5'h00;
					rsr_nxt    = 16'h0000;
					frame_on_nxt = !master && sync_seen;
					// Early pulse needs a spare bit window first
					state_nxt = (master && framed && !fsd && !fedge) ?
						spcf_pkg::ST_SYNC : spcf_pkg::ST_XFER; // [R15]
				end
			end
			spcf_pkg::ST_SYNC: begin
				if (bit_end) begin
					state_nxt = spcf_pkg::ST_XFER;
				end
			end
			spcf_pkg::ST_XFER: begin
				if (sample) begin
					rsr_nxt = {rsr_r[14:0], serial_in_pin_i};
				end
				if (master) begin
					// Data changes at each window boundary
					if (bit_end) begin
						sr_nxt     = sr_r << 1;
						bitcnt_nxt = bitcnt_r + 5'h01;
						if (bitcnt_r == nbits - 5'h01) begin
							state_nxt = spcf_pkg::ST_DONE;
						end
					end
				end else if (!sel) begin
					// Deselect mid-word drops the partial word
					state_nxt = spcf_pkg::ST_IDLE;
				end else begin
					if (cke_eff ? trail : (lead && bitcnt_r != 5'h00)) begin
						sr_nxt = sr_r << 1; // [R3]
					end
					if (sample) begin
						bitcnt_nxt = bitcnt_r + 5'h01;
						if (bitcnt_r == nbits - 5'h01) begin
							state_nxt = spcf_pkg::ST_DONE;
						end
					end
				end
			end
			spcf_pkg::ST_DONE: begin
				push         = 1'b1;
				frame_on_nxt = 1'b0;
				state_nxt    = spcf_pkg::ST_IDLE;
			end
		endcase
		if (!en_r) begin
			state_nxt    = spcf_pkg::ST_IDLE; // [R21]
			frame_on_nxt = 1'b0;
		end
		// A write while the holding word is full is ignored
		if (wr_acc && paddr == spcf_pkg::OFS_BUF && !tbf_r) begin
			tx_nxt  = pwdata[15:0];
			tbf_nxt = 1'b1;
		end
	end

	// Receive store and overflow; a set beats a clear
	always_comb begin
		rx_wr      = 2'(rx_rd_r + rx_cnt_r[1:0]);
		rx_rd_nxt  = rx_rd_r;
		rx_cnt_nxt = rx_cnt_r;
		rov_nxt    = rov_r;
		if (wr_acc && paddr == spcf_pkg::OFS_STATUS && !pwdata[spcf_pkg::BS_ROV]) begin
			rov_nxt = 1'b0;
		end
		if (rd_pop) begin
			rx_rd_nxt  = rx_rd_r + 2'h1;
			rx_cnt_nxt = rx_cnt_r - 3'h1;
		end
		if (push && rx_cnt_r >= rx_lim) begin
			rov_nxt = 1'b1; // [R20]
		end else if (push) begin
			rx_cnt_nxt = rx_cnt_nxt + 3'h1;
		end
	end

	// Pin drive, registered so every output comes from a flop
	always_comb begin
		fs_pulse = (state_r == spcf_pkg::ST_SYNC) || (master && fedge &&
			state_r == spcf_pkg::ST_XFER && bitcnt_r == 5'h00); // [R15]
		sck_oe_nxt = en_r && master;                               // [R7]
		// Clock rests in the spare sync window so the far side counts only data bits
		sck_o_nxt  = clock_idle_level ^ (run && state_r == spcf_pkg::ST_XFER && (first_half ^ cke_eff)); // [R6] [R3] [R15]
		sdo_oe_nxt = en_r && (master || sel);
		sdo_o_nxt  = ctrl1_r[spcf_pkg::B1_WORD] ? sr_r[15] : sr_r[7];
		ss_oe_nxt  = en_r && framed && !fsd;                       // [R13]
		ss_o_nxt   = fs_pulse ? fpol : !fpol;                      // [R14]
	end

	// Receive array written only on an accepted push
	always_ff @(posedge core_clk) begin
		if (push && rx_cnt_r < rx_lim) begin
			rx_mem[rx_wr] <= rx_word;
		end
	end

	// All state registers except the receive array
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl1_r    <= spcf_pkg::CTRL_RESET; // [R17]
			ctrl2_r    <= spcf_pkg::CTRL_RESET;
			en_r       <= 1'b0;
			rov_r      <= 1'b0;
			tbf_r      <= 1'b0;
			tx_r       <= 16'h0000;
			prdata_r   <= 32'h0000_0000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			state_r    <= spcf_pkg::ST_IDLE;
			sr_r       <= 16'h0000;
			rsr_r      <= 16'h0000;
			bitcnt_r   <= 5'h00;
			sck_q_r    <= 1'b0;
			frame_on_r <= 1'b0;
			rx_rd_r    <= 2'h0;
			rx_cnt_r   <= 3'h0;
			sck_o_r    <= 1'b0;
			sck_oe_r   <= 1'b0;
			sdo_o_r    <= 1'b0;
			sdo_oe_r   <= 1'b0;
			ss_o_r     <= 1'b1;
			ss_oe_r    <= 1'b0;
		end else begin
			ctrl1_r    <= ctrl1_nxt;
			ctrl2_r    <= ctrl2_nxt;
			en_r       <= en_nxt;
			rov_r      <= rov_nxt;
			tbf_r      <= tbf_nxt;
			tx_r       <= tx_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
			state_r    <= state_nxt;
			sr_r       <= sr_nxt;
			rsr_r      <= rsr_nxt;
			bitcnt_r   <= bitcnt_nxt;
			sck_q_r    <= serial_clock_pin_i;
			frame_on_r <= frame_on_nxt;
			rx_rd_r    <= rx_rd_nxt;
			rx_cnt_r   <= rx_cnt_nxt;
			sck_o_r    <= sck_o_nxt;
			sck_oe_r   <= sck_oe_nxt;
			sdo_o_r    <= sdo_o_nxt;
			sdo_oe_r   <= sdo_oe_nxt;
			ss_o_r     <= ss_o_nxt;
			ss_oe_r    <= ss_oe_nxt;
		end
	end

	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign serial_clock_pin_o    = sck_o_r;
	assign serial_clock_pin_oe   = sck_oe_r;
	assign serial_out_pin_o      = sdo_o_r;
	assign serial_out_pin_oe     = sdo_oe_r;
	assign slave_select_pin_n_o  = ss_o_r;
	assign slave_select_pin_n_oe = ss_oe_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Frame start with early sync
	sequence s_early_sync;
		state_r == spcf_pkg::ST_IDLE ##1 state_r == spcf_pkg::ST_SYNC;
	endsequence

	a_sync_slot_out: assert property (s_early_sync |=> slave_select_pin_n_o == fpol) // [R15]
		else $error("early sync pulse missing");
	a_idle_clock_lvl: assert property (en_r && state_r == spcf_pkg::ST_IDLE && $stable(clock_idle_level) // [R6]
		|=> serial_clock_pin_o == clock_idle_level) else $error("clock not idle");
	a_role_clock_oe: assert property (en_r |=> serial_clock_pin_oe == $past(master)) // [R7]
		else $error("clock enable does not follow role");
	a_master_start: assert property (en_r && master && !framed && tbf_r && // [R19]
		state_r == spcf_pkg::ST_IDLE |=> state_r == spcf_pkg::ST_XFER && !tbf_r)
		else $error("master did not start");
	a_rov_on_full: assert property (push && rx_cnt_r >= rx_lim |=> rov_r) // [R20]
		else $error("overflow not flagged");
	a_ss_abort: assert property (en_r && !master && !framed && ctrl1_r[spcf_pkg::B1_SSUSE] && // [R5]
		slave_select_pin_n_i && state_r == spcf_pkg::ST_XFER |=> state_r == spcf_pkg::ST_IDLE)
		else $error("slave kept running deselected");
	a_word_len: assert property (state_r == spcf_pkg::ST_XFER ##1 state_r == spcf_pkg::ST_DONE // [R18]
		|-> bitcnt_r == nbits) else $error("wrong bit count");
	a_ctrl2_zero: assert property (ctrl2_r[12:2] == 11'h000) // [R17]
		else $error("unused bits set");
	a_disable_pins: assert property (!en_r |=> !serial_clock_pin_oe && !serial_out_pin_oe // [R21]
		&& !slave_select_pin_n_oe) else $error("pins driven while disabled");
	a_sample_end: assert property (master && sample_phase_sel && state_r == spcf_pkg::ST_XFER && // [R1]
		!bit_end |-> rsr_nxt == rsr_r) else $error("sampled off the window end");
endmodule // spcf_top
`default_nettype wire

// ===== dv/spcf_peer.sv
`timescale 1ns/100ps
`default_nettype none
// Far-end serial slave: sends one word, captures the port's word
module spcf_peer (
	input  wire logic        sck,   // Clock wire
	input  wire logic        cpol,  // Clock idle level
	input  wire logic        cedge, // Port edge select
	input  wire logic        w16,   // Word size
	input  wire logic        load,  // Arm with a new word
	input  wire logic [15:0] tx,    // Word to send
	input  wire logic        sdo,   // Port data out
	output var  logic        sdi,   // Data to port
	output var  logic [15:0] rx,    // Captured word
	output var  int          nbit   // Bits captured
);
	logic [15:0] sh;   // Outgoing shift store
	logic        prev; // Last clock level
	// Idle until armed
	initial begin
		nbit = 99;
		sdi = 1'b0;
		rx = 16'h0000;
	end
	// MSB waits on the line before the first clock
	always @(posedge load) begin
		sh = w16 ? tx : {tx[7:0], 8'h00};
		sdi = sh[15];
		nbit = 0;
		rx = 16'h0000;
		prev = sck;
	end
	// Sample on one edge, shift on the other, never before a first sample
	always @(sck) begin
		if (nbit <= (w16 ? 16 : 8) && sck !== prev) begin
			if ((sck != cpol) == cedge) begin
				if (nbit < (w16 ? 16 : 8)) begin
					rx = {rx[14:0], sdo};
					nbit++;
				end
			end else if (nbit > 0) begin
				// Last bit holds to its shift edge, then the released line shows its inverse
				sh = sh << 1;
				sdi = (nbit == (w16 ? 16 : 8)) ? ~sdi : sh[15];
			end
		end
		prev = sck;
	end
endmodule // spcf_peer
`default_nettype wire

// ===== dv/spcf_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module spcf_tb_top;
	logic        core_clk = 1'b0; // Core clock
	logic        rst = 1'b1;      // Sync reset
	logic        psel = 1'b0;     // APB select
	logic        penable = 1'b0;  // APB enable
	logic        pwrite = 1'b0;   // APB direction
	logic [7:0]  paddr = 8'h00;   // APB address
	logic [31:0] pwdata = 32'h0;  // APB write data
	logic [31:0] prdata;          // APB read data
	logic        pready, pslverr; // APB answer
	logic        sck_o, sck_oe;   // Clock drive
	logic        sdo, sdo_oe;     // Data out
	logic        sdi;             // Data in
	logic        ss_o, ss_oe;     // Sync drive
	logic        ss_tb = 1'b1;    // Select from far side
	logic        sck_tb = 1'b0;   // Clock from far master
	logic        p_cpol = 1'b0;   // Peer settings
	logic        p_edge = 1'b0;
	logic        p_w16 = 1'b0;
	logic        p_load = 1'b0;
	logic [15:0] p_tx = 16'h0;
	logic [15:0] p_rx;
	int          p_nbit;
	logic        fs_act = 1'b0;   // Active sync level
	int          n_fail = 0, n_tests = 0, ts, tl1, tl2;
	wire logic   sck_w = sck_oe ? sck_o : sck_tb; // Clock wire: port drive when enabled, else far master
	wire logic   ss_w = ss_oe ? ss_o : ss_tb;
	localparam logic [15:0] CFG [7] = '{16'h003f, 16'h017b, 16'h062a, 16'h0363, 16'h002b, 16'h003d, 16'h043c};
	localparam int RT [7] = '{2, 2, 24, 8, 6, 16, 64};
	// Clock
	always #50 core_clk = ~core_clk;
	spcf_top u_spcf_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
		.serial_clock_pin_oe(sck_oe), .serial_out_pin_o(sdo), .serial_out_pin_oe(sdo_oe),
		.serial_in_pin_i(sdi), .slave_select_pin_n_i(ss_w), .slave_select_pin_n_o(ss_o),
		.slave_select_pin_n_oe(ss_oe));
	spcf_peer u_spcf_peer (.sck(sck_w), .cpol(p_cpol), .cedge(p_edge), .w16(p_w16), .load(p_load),
		.tx(p_tx), .sdo(sdo), .sdi(sdi), .rx(p_rx), .nbit(p_nbit));
	task finish_test;
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Hung wait ends the run
	task bomb;
		n_fail++;
		$display("[ERR] %0t wait ran out", $time);
		finish_test;
	endtask
	// One APB transfer, held until pready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i <= 16; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (i > 16)
			bomb;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// Reset values, read-only holes, unmapped place
	task regs;
		logic [31:0] q;
		logic        e;
		rd(spcf_pkg::OFS_STATUS, q);
		chk(q, 32'h0);
		wr(spcf_pkg::OFS_CTRL1, 32'hffffffff);
		rd(spcf_pkg::OFS_CTRL1, q);
		chk(q, 32'h07ff);
		wr(spcf_pkg::OFS_CTRL2, 32'hffffffff);
		rd(spcf_pkg::OFS_CTRL2, q);
		chk(q, 32'he003);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk({q[31:1], e}, 32'h1);
	endtask
	// Reconfigure with the port off, then enable
	task cfg(input logic [15:0] c1, input logic [15:0] c2);
		wr(spcf_pkg::OFS_STATUS, 32'h0);
		// Pins are registered, so they follow one edge after the write lands
		@(posedge core_clk);
		chk(sck_oe, 1'b0);
		wr(spcf_pkg::OFS_CTRL1, {16'h0, c1});
		wr(spcf_pkg::OFS_CTRL2, {16'h0, c2});
		wr(spcf_pkg::OFS_STATUS, 32'h8000);
		p_cpol <= c1[6];
		p_edge <= c1[8];
		p_w16 <= c1[10];
		@(posedge core_clk);
		chk(sck_oe, c1[5]);
		chk(sck_w, c1[6] & c1[5]);
		chk(ss_oe, c2[15] & !c2[14]);
	endtask
	// One master word; times sync and clock edges
	task xfer(input logic [15:0] tx, input logic [15:0] ptx, input int r, input logic [31:0] st);
		logic [31:0] q;
		int          i, n;
		logic        lv;
		n = p_w16 ? 16 : 8;
		p_tx <= ptx;
		p_load <= 1'b1;
		@(posedge core_clk);
		p_load <= 1'b0;
		ts = -1;
		tl1 = -1;
		tl2 = -1;
		wr(spcf_pkg::OFS_BUF, {16'h0, tx});
		lv = sck_w;
		for (i = 0; i < 4000 && p_nbit < n; i++) begin
			@(posedge core_clk);
			if (ts < 0 && ss_oe === 1'b1 && ss_o === fs_act)
				ts = i;
			if (sck_w !== lv && sck_w !== p_cpol) begin
				if (tl1 < 0)
					tl1 = i;
				else if (tl2 < 0)
					tl2 = i;
			end
			lv = sck_w;
		end
		if (i >= 4000)
			bomb;
		chk(tl2 - tl1, r);
		chk(p_rx, n == 16 ? tx : {8'h0, tx[7:0]});
		repeat (2 * r + 4) @(posedge core_clk);
		rd(spcf_pkg::OFS_STATUS, q);
		chk(q & 32'h43, st);
	endtask
	// Oldest received word
	task pop(input logic [15:0] ptx);
		logic [31:0] q;
		rd(spcf_pkg::OFS_BUF, q);
		chk(q, p_w16 ? ptx : {8'h0, ptx[7:0]});
	endtask
	// Every primary divider code, both edges, both phases, both sizes
	task sweep;
		for (int k = 0; k < 7; k++) begin
			cfg(CFG[k], 16'h0);
			xfer(16'ha5c3 ^ k, 16'h3c5a + k, RT[k], 32'h1);
			pop(16'h3c5a + k);
		end
		cfg(16'h0080, 16'h0);
	endtask
	// Deep store keeps two words, legacy drops the second
	task store;
		logic [31:0] q;
		cfg(16'h003f, 16'h0001);
		xfer(16'h0011, 16'h0022, 2, 32'h0);
		xfer(16'h0033, 16'h0044, 2, 32'h0);
		pop(16'h0022);
		pop(16'h0044);
		cfg(16'h003f, 16'h0000);
		xfer(16'h0055, 16'h0066, 2, 32'h1);
		xfer(16'h0077, 16'h0088, 2, 32'h41);
		pop(16'h0066);
		wr(spcf_pkg::OFS_STATUS, 32'h8000);
		rd(spcf_pkg::OFS_STATUS, q);
		chk(q & 32'h43, 32'h0);
	endtask
	// Sync polarity and placement as frame master
	task framing;
		for (int f = 0; f < 4; f++) begin
			fs_act <= f[0];
			cfg(16'h003b, {1'b1, 1'b0, f[0], 11'h0, f[1], 1'b0});
			chk(ss_o, !f[0]);
			xfer(16'h0081, 16'h00f0, 2, 32'h1);
			pop(16'h00f0);
			chk(tl1 - ts, f[1] ? 0 : 2);
		end
		cfg(16'h003b, 16'hc000);
	endtask
	// Slave word clocked by the bench with select held, then a deselect
	task slave;
		logic [31:0] q;
		cfg(16'h0080, 16'h0);
		wr(spcf_pkg::OFS_BUF, 32'h0000_00c6);
		p_tx <= 16'h005a;
		p_load <= 1'b1;
		ss_tb <= 1'b0;
		@(posedge core_clk);
		p_load <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			repeat (4) @(posedge core_clk);
			sck_tb <= ~sck_tb;
		end
		repeat (4) @(posedge core_clk);
		ss_tb <= 1'b1;
		chk(p_rx, 32'h00c6);
		pop(16'h005a);
		rd(spcf_pkg::OFS_STATUS, q);
		chk(q & 32'h43, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		regs;
		sweep;
		store;
		framing;
		slave;
		finish_test;
	end
endmodule // spcf_tb_top
`default_nettype wire
